// File: logic/lsc_slave_lin.sv
// Purpose: slave lin controller, status, interrupt and bit-time engine
// Assumes: one clock mclk at 50 MHz, synchronous active-low rstn
// Notes: lin auto-sync is not provided; both modes use bit_time_count
//
// Added by the designer: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/10ps

module lsc_slave_lin
  import lsc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // lin pins
  input wire logic lin_receive_pin,
  output logic lin_tx,
  // processor interrupt
  output logic irq
);

  typedef enum logic [1:0] {ST_IDLE, ST_RX, ST_TX} lsc_state_e;

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] ctrl1_reg; // control_register_one
  logic woc_done_reg; // write_once_config already written
  logic ack_reg; // reset_mode_confirm
  logic [7:0] btc_reg; // bit_time_count
  logic [7:0] frame_reg; // mode, ignore, go, checksum, length
  logic [3:0] evt_reg; // sticky event sources
  logic [7:0] mask_reg; // event mask, low nibble used
  logic flag_reg; // pending_irq_flag
  logic act_reg; // bus_activity_semaphore
  logic [7:0] buf_mem [0:7]; // message bytes
  // engine
  lsc_state_e st_reg;
  logic [7:0] cnt_reg; // clocks within bit
  logic [3:0] bit_reg; // bit index in byte
  logic [3:0] byte_reg; // byte index in frame
  logic [9:0] sh_reg; // shift register
  logic [7:0] sum_reg; // running checksum
  // receive input chain
  logic s1_reg; // first sync stage
  logic s2_reg; // second sync stage
  logic filt_reg; // filtered level
  logic filt_d_reg; // filtered level, delayed
  logic [4:0] fcnt_reg; // stability counter

  ////////////////////////////////////////////////////////////////////////
  // bus decode
  wire wr_en = avs_write & ~avs_waitrequest;
  wire rd_take = avs_read & avs_waitrequest;
  wire [7:0] wd = avs_writedata[7:0];
  wire sel_ctrl1 = avs_address == OFS_CTRL1;
  wire sel_stat = avs_address == OFS_STAT;
  wire sel_svec = avs_address == OFS_SVEC;
  wire sel_btc = avs_address == OFS_BTC;
  wire sel_frame = avs_address == OFS_FRAME;
  wire sel_evt = avs_address == OFS_EVT;
  wire sel_mask = avs_address == OFS_MASK;
  wire sel_buf = avs_address[7:5] == OFS_BUF_HI && avs_address[1:0] == 2'h0;
  wire [2:0] buf_idx = avs_address[4:2];

  ////////////////////////////////////////////////////////////////////////
  // frame and event decode
  wire bit_time_mode = frame_reg[FR_BTM];
  wire ign = frame_reg[FR_IGN];
  wire [3:0] nbytes = {1'b0, frame_reg[FR_LEN +: 3]} + 4'h1;
  wire bit_end = cnt_reg == btc_reg - 8'h01;
  wire sample = cnt_reg == {1'b0, btc_reg[7:1]};
  wire filt_fall = filt_d_reg & ~filt_reg;
  wire [7:0] rx_byte = sh_reg[8:1];
  wire [7:0] sum_out = frame_reg[FR_CHK] ? sum_reg : ~sum_reg;
  wire rx_last = st_reg == ST_RX && bit_end && bit_reg == 4'h9;
  wire rx_chk = rx_last && byte_reg == nbytes;
  wire tx_last = st_reg == ST_TX && bit_end && bit_reg == 4'h9;
  wire tx_bad = st_reg == ST_TX && bit_end && filt_reg != sh_reg[0];
  // byte_reg has stepped past the checksum when the last stop bit ends
  wire tx_done = tx_last && !tx_bad && byte_reg == nbytes + 4'h1;
  logic [3:0] ev_set; // one-cycle event pulses
  assign ev_set[EV_RXOK] = rx_chk && !ign && rx_byte == sum_out;
  assign ev_set[EV_CHKERR] = rx_chk && !ign && rx_byte != sum_out;
  assign ev_set[EV_TXOK] = tx_done;
  assign ev_set[EV_TXERR] = tx_bad;
  wire [3:0] pend = evt_reg & mask_reg[3:0];
  // priority: tx error, checksum error, rx ok, tx ok
  wire [3:0] top = pend[EV_TXERR] ? 4'h8 : pend[EV_CHKERR] ? 4'h4 :
                   pend[EV_RXOK] ? 4'h1 : pend[EV_TXOK] ? 4'h2 : 4'h0;
  wire flag_clr = wr_en && sel_stat && wd[STAT_FLAG];
  wire [3:0] evt_clr = (wr_en && sel_evt ? wd[3:0] : 4'h0) |
                       (flag_clr ? top : 4'h0);
  wire [3:0] evt_next = (evt_reg & ~evt_clr) | ev_set;
  wire new_irq = |(ev_set & mask_reg[3:0]);
  wire flag_next = flag_clr ? new_irq : (flag_reg | (|pend));
  wire act_next = filt_fall | (act_reg &
                  ~(ev_set[EV_RXOK] | ev_set[EV_TXOK]));
  wire [7:0] st_code = st_reg == ST_RX ? SV_RXBUSY :
                       st_reg == ST_TX ? SV_TXBUSY : SV_IDLE;
  wire [7:0] svec = pend[EV_TXERR] ? SV_TXERR : pend[EV_CHKERR] ? SV_CHKERR :
                    pend[EV_RXOK] ? SV_RXOK : pend[EV_TXOK] ? SV_TXOK :
                    st_code;
  // activity has no meaning in bit-time mode, so it reads zero there
  wire [7:0] stat_rd = {act_reg & ~bit_time_mode, 1'b0, ack_reg, 4'h0,
                        flag_reg};
  wire [7:0] rd_mux = sel_ctrl1 ? ctrl1_reg : sel_stat ? stat_rd :
                      sel_svec ? svec : sel_btc ? btc_reg :
                      sel_frame ? frame_reg : sel_evt ? {4'h0, evt_reg} :
                      sel_mask ? mask_reg : sel_buf ? buf_mem[buf_idx] :
                      8'h00;

  // checksum add with end-around carry
  function automatic logic [7:0] csum_add(logic [7:0] a, logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[7:0] + {7'h0, s[8]};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // bus handshake: one wait cycle, then read data stands with wait low
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
    end
    else
    begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      if (rd_take)
        avs_readdata <= {24'h0, rd_mux}; // unmapped reads zero
    end
  end

  // control one: request stays writable so software can leave reset
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      ctrl1_reg <= CTRL1_RST;
      woc_done_reg <= 1'b0;
      ack_reg <= 1'b1;
    end
    else
    begin
      ack_reg <= ctrl1_reg[CTRL1_REQ];
      if (wr_en && sel_ctrl1)
      begin
        ctrl1_reg[CTRL1_REQ] <= wd[CTRL1_REQ];
        // write once: later writes leave the bit as it is
        if (!woc_done_reg)
        begin
          ctrl1_reg[CTRL1_WOC] <= wd[CTRL1_WOC];
          woc_done_reg <= 1'b1;
        end
      end
      if (ack_reg)
        ctrl1_reg[CTRL1_IE] <= CTRL1_RST[CTRL1_IE];
      else if (wr_en && sel_ctrl1)
        ctrl1_reg[CTRL1_IE] <= wd[CTRL1_IE];
    end
  end

  // configuration, status and events, held at reset while confirmed
  always_ff @(posedge mclk)
  begin
    if (!rstn || ack_reg)
    begin
      btc_reg <= BTC_RST;
      frame_reg <= FRAME_RST;
      mask_reg <= MASK_RST;
      evt_reg <= 4'h0;
      flag_reg <= 1'b0;
      act_reg <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      if (wr_en && sel_btc)
        btc_reg <= wd;
      if (wr_en && sel_mask)
        mask_reg <= wd;
      // go clears itself at frame end; engine wins over software
      if (tx_done || tx_bad)
        frame_reg[FR_GO] <= 1'b0;
      else if (wr_en && sel_frame)
        frame_reg <= wd;
      evt_reg <= evt_next; // set wins over clear
      flag_reg <= flag_next;
      act_reg <= act_next;
      irq <= flag_reg & ctrl1_reg[CTRL1_IE];
    end
  end

  // message buffer, written by software or by the receiver
  always_ff @(posedge mclk)
  begin
    if (rx_last && byte_reg < nbytes)
      buf_mem[byte_reg[2:0]] <= rx_byte;
    else if (wr_en && sel_buf && !ack_reg)
      buf_mem[buf_idx] <= wd;
  end

  ////////////////////////////////////////////////////////////////////////
  // receive sync and filter: level must hold FILT_CYC clocks
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      filt_reg <= 1'b1;
      filt_d_reg <= 1'b1;
      fcnt_reg <= 5'h0;
    end
    else
    begin
      s1_reg <= lin_receive_pin;
      s2_reg <= s1_reg;
      filt_d_reg <= filt_reg;
      if (s2_reg == filt_reg)
        fcnt_reg <= 5'h0;
      else if (fcnt_reg == FILT_LAST)
      begin
        filt_reg <= s2_reg;
        fcnt_reg <= 5'h0;
      end
      else
        fcnt_reg <= fcnt_reg + 5'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bit engine: half duplex, one byte per start bit
  always_ff @(posedge mclk)
  begin
    if (!rstn || ack_reg)
    begin
      st_reg <= ST_IDLE;
      cnt_reg <= 8'h0;
      bit_reg <= 4'h0;
      byte_reg <= 4'h0;
      sh_reg <= 10'h3ff;
      sum_reg <= 8'h0;
      lin_tx <= 1'b1;
    end
    else
    begin
      lin_tx <= st_reg == ST_TX ? sh_reg[0] : 1'b1;
      case (st_reg)
        ST_IDLE:
        begin
          cnt_reg <= 8'h0;
          bit_reg <= 4'h0;
          // stale partial receive is dropped when transmit starts
          if (frame_reg[FR_GO])
          begin
            st_reg <= ST_TX;
            sh_reg <= {1'b1, buf_mem[0], 1'b0};
            sum_reg <= csum_add(8'h0, buf_mem[0]);
            byte_reg <= 4'h1;
          end
          else if (filt_fall)
          begin
            st_reg <= ST_RX;
            if (byte_reg == 4'h0)
              sum_reg <= 8'h0;
          end
        end
        ST_RX:
        begin
          cnt_reg <= bit_end ? 8'h0 : cnt_reg + 8'h1;
          if (sample)
          begin
            sh_reg <= {filt_reg, sh_reg[9:1]};
            // a glitch start bit returns to idle
            if (bit_reg == 4'h0 && filt_reg)
              st_reg <= ST_IDLE;
          end
          if (bit_end)
            bit_reg <= bit_reg + 4'h1;
          if (rx_last)
          begin
            // back-to-back bytes: the next start lands on this very edge
            st_reg <= filt_fall ? ST_RX : ST_IDLE;
            bit_reg <= 4'h0;
            if (rx_chk)
            begin
              byte_reg <= 4'h0;
              sum_reg <= 8'h0;
            end
            else
            begin
              sum_reg <= csum_add(sum_reg, rx_byte);
              byte_reg <= byte_reg + 4'h1;
            end
          end
        end
        ST_TX:
        begin
          cnt_reg <= bit_end ? 8'h0 : cnt_reg + 8'h1;
          if (tx_bad || tx_done)
          begin
            st_reg <= ST_IDLE;
            byte_reg <= 4'h0;
            sh_reg <= 10'h3ff;
          end
          else if (tx_last)
          begin
            bit_reg <= 4'h0;
            byte_reg <= byte_reg + 4'h1;
            if (byte_reg < nbytes)
            begin
              sh_reg <= {1'b1, buf_mem[byte_reg[2:0]], 1'b0};
              sum_reg <= csum_add(sum_reg, buf_mem[byte_reg[2:0]]);
            end
            else
              sh_reg <= {1'b1, sum_out, 1'b0};
          end
          else if (bit_end)
          begin
            bit_reg <= bit_reg + 4'h1;
            sh_reg <= {1'b1, sh_reg[9:1]};
          end
        end
        default:
          st_reg <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_act_on_fall: assert property (@(posedge mclk) disable iff (!rstn)
    !ack_reg && filt_fall |=> act_reg)
    else $error("activity not set after filtered falling edge");
  a_act_clear_src: assert property (@(posedge mclk) disable iff (!rstn)
    !ack_reg && $fell(act_reg) |->
    $past(ev_set[EV_RXOK] | ev_set[EV_TXOK]))
    else $error("activity cleared without rx-ok or tx-ok");
  a_act_btm_read: assert property (@(posedge mclk) disable iff (!rstn)
    bit_time_mode |-> !stat_rd[STAT_ACT] && stat_rd[STAT_ACK] == ack_reg)
    else $error("status bits wrong in bit-time mode");
  a_hold_reset: assert property (@(posedge mclk) disable iff (!rstn)
    ack_reg ##1 ack_reg |-> btc_reg == BTC_RST && mask_reg == MASK_RST
    && !flag_reg && !irq)
    else $error("register left reset value while confirmed");
  a_confirm_follow: assert property (@(posedge mclk) disable iff (!rstn)
    $fell(ctrl1_reg[CTRL1_REQ]) |=> !ack_reg)
    else $error("confirm did not drop after request cleared");
  a_flag_w1c: assert property (@(posedge mclk) disable iff (!rstn)
    !ack_reg && flag_clr && !new_irq |=> !flag_reg)
    else $error("pending flag not cleared by write");
  a_flag_again: assert property (@(posedge mclk) disable iff (!rstn)
    !ack_reg && flag_clr && |(pend & ~top) && !(wr_en && sel_mask)
    ##1 !ack_reg |=> flag_reg)
    else $error("pending flag not set again");
  a_irq_level: assert property (@(posedge mclk) disable iff (!rstn)
    (!ack_reg && flag_reg && ctrl1_reg[CTRL1_IE]) [*2] |-> irq)
    else $error("interrupt output missing");
  a_bit_length: assert property (@(posedge mclk) disable iff (!rstn)
    st_reg == ST_TX && $past(st_reg) == ST_TX && $changed(bit_reg)
    |-> cnt_reg == 8'h0 && $past(cnt_reg) == btc_reg - 8'h01)
    else $error("transmit bit length wrong");
  a_filter_min: assert property (@(posedge mclk) disable iff (!rstn)
    $changed(filt_reg) |-> $past(s2_reg, 1) == filt_reg &&
    $past(s2_reg, 8) == filt_reg && $past(s2_reg, 16) == filt_reg)
    else $error("filter passed a short pulse");

endmodule // lsc_slave_lin

// File: logic/lsc_pkg.sv
// Purpose: constants for the slave lin controller register block
// Assumes: 8-bit registers in the low byte of 32-bit avalon words
// Notes: offsets are byte addresses
package lsc_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL1 = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_SVEC = 8'h08;
  localparam logic [7:0] OFS_BTC = 8'h0c;
  localparam logic [7:0] OFS_FRAME = 8'h10;
  localparam logic [7:0] OFS_EVT = 8'h14;
  localparam logic [7:0] OFS_MASK = 8'h18;
  localparam logic [2:0] OFS_BUF_HI = 3'h1; // message buffer 0x20..0x3c
  // control_register_one fields
  localparam int CTRL1_REQ = 7; // reset_mode_request
  localparam int CTRL1_WOC = 6; // write_once_config
  localparam int CTRL1_IE = 1; // module interrupt enable
  // lin_status_register fields
  localparam int STAT_ACT = 7;
  localparam int STAT_ACK = 5;
  localparam int STAT_FLAG = 0;
  // frame control fields
  localparam int FR_BTM = 0;
  localparam int FR_IGN = 1;
  localparam int FR_GO = 2;
  localparam int FR_CHK = 3;
  localparam int FR_LEN = 4; // 3-bit length, bytes = value + 1
  // event bits
  localparam int EV_RXOK = 0;
  localparam int EV_TXOK = 1;
  localparam int EV_CHKERR = 2;
  localparam int EV_TXERR = 3;
  // state vector codes
  localparam logic [7:0] SV_IDLE = 8'h00;
  localparam logic [7:0] SV_RXBUSY = 8'h04;
  localparam logic [7:0] SV_TXOK = 8'h08;
  localparam logic [7:0] SV_TXBUSY = 8'h0c;
  localparam logic [7:0] SV_RXOK = 8'h10;
  localparam logic [7:0] SV_TXERR = 8'h18;
  localparam logic [7:0] SV_CHKERR = 8'h1c;
  // reset values
  localparam logic [7:0] CTRL1_RST = 8'h80;
  localparam logic [7:0] BTC_RST = 8'h22;
  localparam logic [7:0] FRAME_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  // timing
  localparam int CLK_NS = 20;
  localparam int FILT_NS = 320;
  localparam int FILT_CYC = (FILT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [4:0] FILT_LAST = 5'(FILT_CYC - 1);
endpackage

// File: tb/lsc_lin_master.sv
// Purpose: lin master node model driving the shared bus line
// Assumes: open-drain bus with pull-up, so released level is high
// Notes: 8n1 bytes lsb first, bit length given in mclk cycles
`timescale 1ns/10ps
module lsc_lin_master
(
  // clock
  input wire logic mclk,
  // pull-down side of the shared line
  output logic drv
);
  // released line reads high through the pull-up
  initial drv = 1'b1;

  //////////////////////////////////////////////////////////////////////
  // one byte: start, eight data bits, stop
  task automatic send_byte(input logic [7:0] b, input int bt);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge mclk);
      drv <= f[i];
      repeat (bt - 1) @(posedge mclk);
    end
  endtask

  // short low pulse, used to probe the receive filter
  task automatic glitch(input int n);
    @(posedge mclk);
    drv <= 1'b0;
    repeat (n) @(posedge mclk);
    drv <= 1'b1;
  endtask
endmodule // lsc_lin_master

// File: tb/testbench.sv
// Purpose: self-checking bench for the slave lin controller
// Assumes: avalon master tasks, lin master model on the bus line
// Notes: register rows first, then lin traffic and interrupts
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module testbench;
  import lsc_pkg::*;
  // clock, reset and bus signals
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic lin_tx;
  logic irq;
  logic m_drv;
  wire lin_bus = m_drv & lin_tx; // wired-and with pull-up
  int failures = 0;
  int checks_done = 0;
  logic [7:0] q;
  int cnt;
  logic [18:0] txf; // line samples of a transmitted frame
  // register rows: address, write, write data, expected readback
  typedef struct packed
  {
    logic [7:0] a;
    logic w;
    logic [7:0] d;
    logic [7:0] e;
  } lsc_row_s;
  lsc_row_s rows [10] = '{'{8'h0c, 1'b1, 8'h10, 8'h22},
    '{8'h18, 1'b1, 8'h0f, 8'h00}, '{8'h04, 1'b1, 8'h00, 8'h20},
    '{8'h08, 1'b0, 8'h00, 8'h00}, '{8'h00, 1'b1, 8'h02, 8'h00},
    '{8'h04, 1'b0, 8'h00, 8'h00}, '{8'h00, 1'b1, 8'h02, 8'h02},
    '{8'h0c, 1'b1, 8'h14, 8'h14},
    '{8'h18, 1'b1, 8'h0f, 8'h0f}, '{8'hfc, 1'b1, 8'h55, 8'h00}};

  always #10 mclk = ~mclk;

  lsc_slave_lin lsc_slave_lin_inst (.mclk(mclk), .rstn(rstn),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .lin_receive_pin(lin_bus), .lin_tx(lin_tx), .irq(irq));
  lsc_lin_master lsc_lin_master_inst (.mclk(mclk), .drv(m_drv));

  //////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic final_report;
    if (failures == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // one avalon access; request held until waitrequest sampled low
  task automatic bus(input logic [7:0] a, input logic w,
    input logic [7:0] d, output logic [7:0] r);
    int n;
    @(posedge mclk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    for (n = 0; n < 20; n++)
    begin
      @(posedge mclk);
      if (avs_waitrequest === 1'b0)
        break;
    end
    r = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n == 20)
    begin
      failures++; // hung access ends the run
      final_report();
    end
  endtask

  // poll a register until it shows a value, then compare
  task automatic wait_reg(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] r;
    for (int n = 0; n < 300; n++)
    begin
      bus(a, 1'b0, 8'h00, r);
      if (r === e)
        break;
    end
    `CHK(r, e)
  endtask

  //////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    // reset-mode holds, leaving reset mode, plain register access
    foreach (rows[i])
    begin
      if (rows[i].w)
        bus(rows[i].a, 1'b1, rows[i].d, q);
      bus(rows[i].a, 1'b0, 8'h00, q);
      `CHK(q, rows[i].e)
    end
    // short pulse is filtered, long one sets activity
    lsc_lin_master_inst.glitch(10);
    repeat (30) @(posedge mclk);
    wait_reg(OFS_STAT, 8'h00);
    lsc_lin_master_inst.glitch(24);
    wait_reg(OFS_STAT, 8'h80);
    // let the byte started by the long pulse finish
    repeat (220) @(posedge mclk);
    bus(OFS_FRAME, 1'b1, 8'h09, q);
    wait_reg(OFS_STAT, 8'h00);
    // ignored frame leaves activity set and raises nothing
    bus(OFS_FRAME, 1'b1, 8'h0a, q);
    lsc_lin_master_inst.send_byte(8'h11, 20);
    lsc_lin_master_inst.send_byte(8'h11, 20);
    repeat (40) @(posedge mclk);
    wait_reg(OFS_STAT, 8'h80);
    `CHK(irq, 1'b0)
    // transmit with tx ok masked; start bit is exactly btc clocks
    bus(OFS_MASK, 1'b1, 8'h0d, q);
    bus(8'h20, 1'b1, 8'ha5, q);
    bus(OFS_FRAME, 1'b1, 8'h0c, q);
    for (cnt = 0; cnt < 200 && lin_tx !== 1'b0; cnt++)
      @(posedge mclk);
    for (cnt = 0; cnt < 100 && lin_tx === 1'b0; cnt++)
      @(posedge mclk);
    `CHK(cnt, 20)
    // mid-bit samples: data, stop, start, checksum, stop
    repeat (10) @(posedge mclk);
    for (int i = 0; i < 19; i++)
    begin
      txf[i] = lin_tx;
      repeat (20) @(posedge mclk);
    end
    `CHK(txf, {1'b1, 8'ha5, 2'b01, 8'ha5})
    wait_reg(OFS_FRAME, 8'h08);
    `CHK(irq, 1'b0)
    // unmask: flag, interrupt and tx ok code, activity cleared
    bus(OFS_MASK, 1'b1, 8'h0f, q);
    wait_reg(OFS_STAT, 8'h01);
    `CHK(irq, 1'b1)
    wait_reg(OFS_SVEC, SV_TXOK);
    // receive a frame while tx ok still pending
    lsc_lin_master_inst.send_byte(8'h3c, 20);
    lsc_lin_master_inst.send_byte(8'h3c, 20);
    wait_reg(OFS_SVEC, SV_RXOK);
    // clearing flag re-sets it for the remaining source
    bus(OFS_STAT, 1'b1, 8'h01, q);
    wait_reg(OFS_SVEC, SV_TXOK);
    wait_reg(OFS_STAT, 8'h01);
    bus(OFS_STAT, 1'b1, 8'h01, q);
    wait_reg(OFS_STAT, 8'h00);
    repeat (3) @(posedge mclk);
    `CHK(irq, 1'b0)
    // second reset in mid-run returns to reset mode
    rstn <= 1'b0;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    bus(OFS_STAT, 1'b0, 8'h00, q);
    `CHK(q, 8'h20)
    bus(OFS_BTC, 1'b0, 8'h00, q);
    `CHK(q, BTC_RST)
    final_report();
  end
endmodule // testbench
